// >>> src/acqd_defs.svh
// constants of the acquisition capture and dma block
`ifndef ACQD_DEFS_SVH
`define ACQD_DEFS_SVH
`define ACQD_NUM_CHAN      3
`define ACQD_SAMPLE_W      16
`define ACQD_OUT_W         32
`define ACQD_LEN_W         24
`define ACQD_ID_W          8
`define ACQD_TS_W          32
`define ACQD_SRC_W         3
// 1 GB bank seen as a byte address
`define ACQD_BANK_ADDR_W   30
`define ACQD_WORD_STEP     30'h4
`define ACQD_FIFO_DEPTH    4
`define ACQD_SYNC_STAGES   3
`endif

// >>> src/acqd_pkg.sv
// types shared by the acquisition capture and dma block
`default_nettype none
`include "acqd_defs.svh"
package acqd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_ARM, ST_CAP, ST_DRAIN, ST_META0, ST_META1
    } acqd_state_e;
    typedef enum logic [`ACQD_SRC_W-1:0] {
        SRC_ADC0, SRC_ADC1, SRC_ADC2, SRC_TEST, SRC_PLAYBACK
    } acqd_src_e;
endpackage : acqd_pkg
`default_nettype wire

// >>> src/acqd_top.sv
// acquisition paths: sample fifo, per-channel dma engine and top level
`default_nettype none
`include "acqd_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module acqd_fifo #(
    parameter int WIDTH = `ACQD_SAMPLE_W,
    parameter int DEPTH = `ACQD_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } acqd_fifo_s;
    acqd_fifo_s r_reg;
    acqd_fifo_s r_next;
    logic       push;
    logic       pop;

    always_comb begin
        r_next    = r_reg;
        in_ready  = (r_reg.cnt != (AW+1)'(DEPTH));
        out_valid = (r_reg.cnt != '0);
        out_data  = r_reg.mem[r_reg.rp];
        push      = ce && in_valid && in_ready;
        pop       = ce && out_valid && out_ready;
        if (push) begin
            r_next.mem[r_reg.wp] = in_data;
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.cnt <= (AW+1)'(DEPTH))
        else $error("sample fifo holds more words than its depth");
endmodule : acqd_fifo

////////////////////////////////////////////////////////////////////////////////
module acqd_chan
    import acqd_pkg::*;
#(
    parameter logic [`ACQD_ID_W-1:0] CHAN_ID = '0
) (
    input  wire logic                                        clk,
    input  wire logic                                        rst_n,
    input  wire logic                                        ce,
    input  wire logic                                        enable,
    input  wire logic [`ACQD_SRC_W-1:0]                      src_sel,
    input  wire logic                                        transient,
    input  wire logic                                        meta_en,
    input  wire logic [`ACQD_NUM_CHAN-1:0][`ACQD_SAMPLE_W-1:0] adc_data,
    input  wire logic [`ACQD_SAMPLE_W-1:0]                   test_data,
    input  wire logic [`ACQD_SAMPLE_W-1:0]                   playback_data,
    input  wire logic                                        gate_q,
    input  wire logic [`ACQD_TS_W-1:0]                       ts,
    input  wire logic                                        desc_ack,
    input  wire logic [`ACQD_LEN_W-1:0]                      desc_len,
    input  wire logic                                        desc_gated,
    input  wire logic                                        desc_link,
    input  wire logic                                        out_ready,
    output logic                                             desc_req,
    output logic                                             out_valid,
    output logic      [`ACQD_OUT_W-1:0]                      out_data,
    output logic      [`ACQD_BANK_ADDR_W-1:0]                out_addr,
    output logic                                             out_meta,
    output logic                                             out_last,
    output logic                                             xfer_done,
    output logic      [`ACQD_LEN_W-1:0]                      xfer_len,
    output logic                                             overrun
);
    localparam int SW = `ACQD_SAMPLE_W;
    localparam int OW = `ACQD_OUT_W;
    typedef struct packed {
        acqd_state_e                  st;
        logic                         desc_req;
        logic                         gated;
        logic                         link;
        logic                         shot;
        logic                         first;
        logic [`ACQD_LEN_W-1:0]       len;
        logic [`ACQD_LEN_W-1:0]       cnt;
        logic [`ACQD_TS_W-1:0]        ts_lat;
        logic [`ACQD_BANK_ADDR_W-1:0] addr;
        logic                         ov;
        logic                         done;
        logic                         out_valid;
        logic [OW-1:0]                out_data;
        logic [`ACQD_BANK_ADDR_W-1:0] out_addr;
        logic                         out_meta;
        logic                         out_last;
    } acqd_chan_s;
    acqd_chan_s      r;
    acqd_chan_s      n;
    logic [SW-1:0]   sample;
    logic            wr_valid;
    logic            wr_ok;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic [SW-1:0]   fifo_out_data;
    logic            slot_free;
    logic            rd_ready;
    logic            pop;
    logic            close;

    acqd_fifo #(.WIDTH(SW), .DEPTH(`ACQD_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (wr_valid),
        .in_data   (sample),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (rd_ready)
    );

    always_comb begin
        n      = r;
        n.done = 1'b0;
        case (acqd_src_e'(src_sel))
            SRC_ADC0: sample = adc_data[0];
            SRC_ADC1: sample = adc_data[1];
            SRC_ADC2: sample = adc_data[2];
            SRC_TEST: sample = test_data;
            default:  sample = playback_data;
        endcase
        // gate qualifies samples
        // armed gated engine keeps the sample that first finds the gate high
        wr_valid = ce && ((r.st == ST_CAP) || (r.st == ST_ARM)) && gate_q && !(&r.cnt)
                   && (r.gated || (r.cnt < r.len));
        wr_ok    = wr_valid && fifo_in_ready;
        if (wr_valid && !fifo_in_ready) begin
            n.ov = 1'b1;
        end
        if (wr_ok) begin
            n.cnt = r.cnt + 1'b1;
            if (r.first) begin
                n.ts_lat = ts;
                n.first  = 1'b0;
            end
        end
        slot_free = !r.out_valid || out_ready;
        rd_ready  = ce && slot_free && ((r.st == ST_CAP) || (r.st == ST_DRAIN));
        pop       = rd_ready && fifo_out_valid;
        if (slot_free) begin
            n.out_valid = 1'b0;
            n.out_meta  = 1'b0;
            n.out_last  = 1'b0;
        end
        if (pop) begin
            n.out_valid = 1'b1;
            n.out_data  = {{(OW - SW){1'b0}}, fifo_out_data};
            n.out_addr  = r.addr;
            n.addr      = r.addr + `ACQD_WORD_STEP;
        end
        close = r.gated ? (!gate_q || (&r.cnt)) : (r.cnt == r.len);
        case (r.st)
            ST_IDLE: begin
                if (!enable) begin
                    n.shot = 1'b0;
                end else if (!r.shot) begin
                    n.st       = ST_FETCH;
                    n.desc_req = 1'b1;
                end
            end
            ST_FETCH: begin
                if (desc_ack) begin
                    n.desc_req = 1'b0;
                    n.len      = desc_len;
                    n.gated    = desc_gated;
                    n.link     = desc_link;
                    n.cnt      = '0;
                    n.first    = 1'b1;
                    n.ov       = 1'b0;
                    n.st       = desc_gated ? ST_ARM : ST_CAP;
                    if (transient) begin
                        n.addr = '0;
                    end
                end
            end
            ST_ARM: begin
                if (gate_q) begin
                    n.st = ST_CAP;
                end
            end
            ST_CAP: begin
                if (close) begin
                    n.len = r.cnt;
                    n.st  = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!fifo_out_valid && slot_free) begin
                    if (meta_en) begin
                        n.st = ST_META0;
                    end else begin
                        n.done = 1'b1;
                        n.st   = r.link ? ST_FETCH : ST_IDLE;
                        n.desc_req = r.link;
                        n.shot = !r.link && transient;
                    end
                end
            end
            ST_META0: begin
                if (slot_free) begin
                    n.out_valid = 1'b1;
                    n.out_meta  = 1'b1;
                    n.out_data  = {CHAN_ID, r.len};
                    n.out_addr  = r.addr;
                    n.addr      = r.addr + `ACQD_WORD_STEP;
                    n.st        = ST_META1;
                end
            end
            ST_META1: begin
                if (slot_free) begin
                    n.out_valid = 1'b1;
                    n.out_meta  = 1'b1;
                    n.out_last  = 1'b1;
                    n.out_data  = r.ts_lat;
                    n.out_addr  = r.addr;
                    n.addr      = r.addr + `ACQD_WORD_STEP;
                    n.done      = 1'b1;
                    n.st        = r.link ? ST_FETCH : ST_IDLE;
                    n.desc_req  = r.link;
                    n.shot      = !r.link && transient;
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign desc_req  = r.desc_req;
    assign out_valid = r.out_valid;
    assign out_data  = r.out_data;
    assign out_addr  = r.out_addr;
    assign out_meta  = r.out_meta;
    assign out_last  = r.out_last;
    assign xfer_done = r.done;
    assign xfer_len  = r.len;
    assign overrun   = r.ov;

    sequence s_req_open;
        desc_req && !(ce && desc_ack);
    endsequence
    sequence s_meta_go;
        ce && (r.st == ST_META0) && slot_free;
    endsequence

    chk_desc_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_req_open |=> desc_req)
        else $error("descriptor request dropped before acknowledge");
    chk_preset_len: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (r.st == ST_CAP) && !r.gated && (r.cnt == r.len) |=> r.st == ST_DRAIN)
        else $error("preset transfer did not close at its length");
    chk_gate_close: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (r.st == ST_CAP) && r.gated && !gate_q
        |=> (r.st == ST_DRAIN) && (r.len == $past(r.cnt)))
        else $error("gate fall did not close the transfer with its length");
    chk_meta_word: assert property (@(posedge clk) disable iff (!rst_n)
        s_meta_go |=> out_valid && out_meta && (out_data == {CHAN_ID, r.len}))
        else $error("metadata word lacks channel id or length");
    chk_ts_latch: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && r.first |=> r.ts_lat == $past(ts))
        else $error("time stamp not taken at first sample");
    chk_out_hold: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word changed while stalled");
    chk_src_test: assert property (@(posedge clk) disable iff (!rst_n)
        (src_sel == SRC_TEST) |-> sample == test_data)
        else $error("test source not selected");
    chk_trans_addr: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (r.st == ST_FETCH) && desc_ack && transient |=> r.addr == '0)
        else $error("transient block did not restart at bank base");
endmodule : acqd_chan

////////////////////////////////////////////////////////////////////////////////
module acqd_top
    import acqd_pkg::*;
(
    input  wire logic                                        MCLK,
    input  wire logic                                        RESETN,
    input  wire logic                                        CE,
    input  wire logic                                        GATE,
    input  wire logic                                        SYNC,
    input  wire logic [`ACQD_NUM_CHAN-1:0][`ACQD_SAMPLE_W-1:0] ADC_DATA,
    input  wire logic [`ACQD_SAMPLE_W-1:0]                   TEST_DATA,
    input  wire logic [`ACQD_SAMPLE_W-1:0]                   PLAYBACK_DATA,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   ENABLE,
    input  wire logic [`ACQD_NUM_CHAN-1:0][`ACQD_SRC_W-1:0]  SRC_SEL,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   TRANSIENT,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   META_EN,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   DESC_ACK,
    input  wire logic [`ACQD_NUM_CHAN-1:0][`ACQD_LEN_W-1:0]  DESC_LEN,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   DESC_GATED,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   DESC_LINK,
    input  wire logic [`ACQD_NUM_CHAN-1:0]                   OUT_READY,
    output logic      [`ACQD_NUM_CHAN-1:0]                   DESC_REQ,
    output logic      [`ACQD_NUM_CHAN-1:0]                   OUT_VALID,
    output logic      [`ACQD_NUM_CHAN-1:0][`ACQD_OUT_W-1:0]  OUT_DATA,
    output logic      [`ACQD_NUM_CHAN-1:0][`ACQD_BANK_ADDR_W-1:0] OUT_ADDR,
    output logic      [`ACQD_NUM_CHAN-1:0]                   OUT_META,
    output logic      [`ACQD_NUM_CHAN-1:0]                   OUT_LAST,
    output logic      [`ACQD_NUM_CHAN-1:0]                   XFER_DONE,
    output logic      [`ACQD_NUM_CHAN-1:0][`ACQD_LEN_W-1:0]  XFER_LEN,
    output logic      [`ACQD_NUM_CHAN-1:0]                   OVERRUN
);
    typedef struct packed {
        logic [`ACQD_SYNC_STAGES-1:0] gate_sh;
        logic [`ACQD_SYNC_STAGES-1:0] sync_sh;
        logic                         gate_q;
        logic                         sync_q;
        logic [`ACQD_TS_W-1:0]        ts;
    } acqd_top_s;
    acqd_top_s r;
    acqd_top_s n;

    always_comb begin
        n = r;
        // timing bus pins through three stages
        n.gate_sh = {r.gate_sh[1:0], GATE};
        n.sync_sh = {r.sync_sh[1:0], SYNC};
        if (r.gate_sh[1] == r.gate_sh[2]) begin
            n.gate_q = r.gate_sh[2];
        end
        if (r.sync_sh[1] == r.sync_sh[2]) begin
            n.sync_q = r.sync_sh[2];
        end
        n.ts = r.sync_q ? '0 : r.ts + 1'b1;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            r <= '0;
        end else if (CE) begin
            r <= n;
        end
    end

    for (genvar ch = 0; ch < `ACQD_NUM_CHAN; ch++) begin : g_chan
        acqd_chan #(.CHAN_ID(`ACQD_ID_W'(ch))) u_chan (
            .clk           (MCLK),
            .rst_n         (RESETN),
            .ce            (CE),
            .enable        (ENABLE[ch]),
            .src_sel       (SRC_SEL[ch]),
            .transient     (TRANSIENT[ch]),
            .meta_en       (META_EN[ch]),
            .adc_data      (ADC_DATA),
            .test_data     (TEST_DATA),
            .playback_data (PLAYBACK_DATA),
            .gate_q        (r.gate_q),
            .ts            (r.ts),
            .desc_ack      (DESC_ACK[ch]),
            .desc_len      (DESC_LEN[ch]),
            .desc_gated    (DESC_GATED[ch]),
            .desc_link     (DESC_LINK[ch]),
            .out_ready     (OUT_READY[ch]),
            .desc_req      (DESC_REQ[ch]),
            .out_valid     (OUT_VALID[ch]),
            .out_data      (OUT_DATA[ch]),
            .out_addr      (OUT_ADDR[ch]),
            .out_meta      (OUT_META[ch]),
            .out_last      (OUT_LAST[ch]),
            .xfer_done     (XFER_DONE[ch]),
            .xfer_len      (XFER_LEN[ch]),
            .overrun       (OVERRUN[ch])
        );
    end

    chk_ts_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && r.sync_q |=> r.ts == '0)
        else $error("stamp counter not cleared by sync");
    chk_gate_filt: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && (r.gate_sh[1] != r.gate_sh[2]) |=> $stable(r.gate_q))
        else $error("gate changed before two stages agreed");
endmodule : acqd_top
`default_nettype wire

// >>> bench/acqd_host_model.sv
// host dma path model: answers descriptor requests and accepts output words
`default_nettype none
module acqd_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] desc_req,
    input  wire logic [2:0] stall,
    output logic      [2:0] desc_ack,
    output logic      [2:0] out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    assign out_ready = ~stall;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            desc_ack <= 3'h0;
        end else begin
            desc_ack <= desc_req & ~desc_ack;
        end
    end
endmodule : acqd_host_model
`default_nettype wire

// >>> bench/adc_acquisition_capture_dma_test.sv
// self-checking bench for the acquisition capture and dma block
`default_nettype none
`include "acqd_defs.svh"
module adc_acquisition_capture_dma_test
    import acqd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NC = `ACQD_NUM_CHAN;
    logic                mclk, resetn, gate, sync, meta_last, ce;
    logic [15:0]         test_data, playback_data;
    logic [NC-1:0][15:0] adc_data;
    logic [NC-1:0]       enable, transient, meta_en, desc_gated, desc_link, stall, desc_ack;
    logic [NC-1:0]       out_ready, desc_req, out_valid, out_meta, out_last, xfer_done, overrun;
    logic [NC-1:0][2:0]  src_sel;
    logic [NC-1:0][23:0] desc_len, xfer_len;
    logic [NC-1:0][31:0] out_data;
    logic [NC-1:0][29:0] out_addr;
    logic [31:0]         meta_w [2];
    logic [23:0]         len_seen;
    int                  n_words, failures, total_checks;

    acqd_top DUT (
        .MCLK (mclk), .RESETN (resetn), .CE (ce), .GATE (gate), .SYNC (sync),
        .ADC_DATA (adc_data), .TEST_DATA (test_data), .PLAYBACK_DATA (playback_data),
        .ENABLE (enable), .SRC_SEL (src_sel), .TRANSIENT (transient), .META_EN (meta_en),
        .DESC_ACK (desc_ack), .DESC_LEN (desc_len), .DESC_GATED (desc_gated),
        .DESC_LINK (desc_link), .OUT_READY (out_ready), .DESC_REQ (desc_req),
        .OUT_VALID (out_valid), .OUT_DATA (out_data), .OUT_ADDR (out_addr),
        .OUT_META (out_meta), .OUT_LAST (out_last), .XFER_DONE (xfer_done),
        .XFER_LEN (xfer_len), .OVERRUN (overrun)
    );
    acqd_host_model host (
        .clk (mclk), .rst_n (resetn), .desc_req (desc_req), .stall (stall),
        .desc_ack (desc_ack), .out_ready (out_ready)
    );

    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic setup(input int ch, input logic [2:0] src, input logic tr, input logic me,
                         input logic [23:0] len, input logic gt, input logic lk);
        @(posedge mclk);
        src_sel[ch]    <= src;
        transient[ch]  <= tr;
        meta_en[ch]    <= me;
        desc_len[ch]   <= len;
        desc_gated[ch] <= gt;
        desc_link[ch]  <= lk;
        enable[ch]     <= 1'b1;
    endtask : setup

    // gathers one transfer; data words compared on the fly, metadata kept
    task automatic collect(input int ch, input logic [15:0] val, input logic [29:0] addr);
        int nm;
        int post;
        nm = 0;
        post = 0;
        n_words = 0;
        for (int i = 0; i < 800 && post < 10; i++) begin
            @(posedge mclk);
            if (out_valid[ch] && out_ready[ch] && out_meta[ch] && nm < 2) begin
                meta_w[nm] = out_data[ch];
                meta_last = out_last[ch];
                nm++;
            end else if (out_valid[ch] && out_ready[ch] && !out_meta[ch]) begin
                check(out_data[ch], {16'h0, val});
                check({2'h0, out_addr[ch]}, {2'h0, addr});
                addr += 30'h4;
                n_words++;
            end
            if (xfer_done[ch] && post == 0) begin
                len_seen = xfer_len[ch];
            end
            if (xfer_done[ch] || post > 0) begin
                post++;
            end
        end
        check({31'h0, post > 0}, 32'h1);
    endtask : collect

    task automatic gate_pulse(input int n);
        @(posedge mclk);
        gate <= 1'b1;
        repeat (n) @(posedge mclk);
        gate <= 1'b0;
    endtask : gate_pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_gated();
        setup(2, 3'h3, 1'b0, 1'b0, 24'h0, 1'b1, 1'b1);
        repeat (8) @(posedge mclk);
        fork
            collect(2, 16'hb00b, 30'h0);
            gate_pulse(5);
        join
        check(n_words, 5);
        check(len_seen, 24'h5);
        repeat (4) @(posedge mclk);
        fork
            collect(2, 16'hb00b, 30'h14);
            gate_pulse(3);
        join
        check(len_seen, 24'h3);
        enable[2] <= 1'b0;
    endtask : t_gated

    task automatic t_sources();
        logic [15:0] exp;
        for (int s = 0; s < 6; s++) begin
            exp = s < 3 ? adc_data[s] : (s == 3 ? test_data : playback_data);
            setup(0, 3'(s), 1'b1, 1'b0, 24'h2, 1'b0, 1'b0);
            collect(0, exp, 30'h0);
            check(n_words, 2);
            check(len_seen, 24'h2);
            check({31'h0, desc_req[0]}, 32'h0);
            enable[0] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask : t_sources

    task automatic t_meta();
        sync <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 2; k++) begin
            setup(1, 3'h4, 1'b1, 1'b1, 24'h3, 1'b0, 1'b0);
            collect(1, playback_data, 30'h0);
            check(meta_w[0], {8'h01, 24'h3});
            check({31'h0, meta_last}, 32'h1);
            check({31'h0, meta_w[1] == 32'h0}, {31'h0, k == 0});
            enable[1] <= 1'b0;
            sync <= 1'b0;
            repeat (8) @(posedge mclk);
        end
    endtask : t_meta

    task automatic t_overrun();
        stall[0] <= 1'b1;
        setup(0, 3'h3, 1'b1, 1'b0, 24'h20, 1'b0, 1'b0);
        repeat (30) @(posedge mclk);
        check({31'h0, overrun[0]}, 32'h1);
        // clock enable low: the stalled word stays although the host is ready
        ce       <= 1'b0;
        stall[0] <= 1'b0;
        repeat (3) @(posedge mclk);
        check({2'h0, out_addr[0]}, 32'h0);
        check({31'h0, out_valid[0]}, 32'h1);
        ce <= 1'b1;
        collect(0, test_data, 30'h0);
        enable[0] <= 1'b0;
        repeat (4) @(posedge mclk);
        setup(0, 3'h3, 1'b1, 1'b0, 24'h2, 1'b0, 1'b0);
        collect(0, test_data, 30'h0);
        check({31'h0, overrun[0]}, 32'h0);
    endtask : t_overrun

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        gate = 1'b0;
        sync = 1'b0;
        ce = 1'b1;
        adc_data = {16'ha002, 16'ha001, 16'ha000};
        test_data = 16'hb00b;
        playback_data = 16'hc00c;
        {enable, transient, meta_en, desc_gated, desc_link, stall} = '0;
        src_sel = '0;
        desc_len = '0;
        failures = 0;
        total_checks = 0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_gated();
        gate <= 1'b1;
        t_sources();
        t_meta();
        t_overrun();
        complete_run();
    end

    initial begin
        #500000;
        failures++;
        complete_run();
    end
endmodule : adc_acquisition_capture_dma_test
`default_nettype wire
